// ### verilog/rtd_regs.svh
/*
 * Register offsets, field positions, response codes and timing counts for the
 * register transfer datapath, reached over AXI4-Lite.
 * Assumes a 10 MHz aclk and 32-bit aligned register words.
 */
// Notes on behaviour
// [RQ1] Every register can be cleared, set to ones, or fully complemented.
// [RQ2] Jam copies each source bit to the destination in one pulse.
// [RQ3] The source register of any transfer is left unchanged.
// [RQ4] Zeros pulse and ones pulse are separate strobes.
// [RQ5] Split transfer: first pulse clears destination, second sets source ones.
// [RQ6] Zeros-only or ones-only logical transfers are allowed.
// [RQ7] Shift moves every bit one place left or right in one pulse.
// [RQ8] Ring mode feeds the bit shifted out into the opposite end.
// [RQ9] Segmented mode splits the register into small independent rings.
// [RQ10] Permute swaps subwords by copying each into its partner.
// [RQ11] Two-register xor: complement destination bits where source is one.
// [RQ12] Three-register or: clear result, then set where either source is one.
// [RQ13] Or pulse leaves result bits with both sources zero untouched.
// [RQ14] Ones-only transfer leaves destination as old value or source.
// [RQ15] Two-pulse three-register xor clears result, then sets ones.
// [RQ16] Its set pulse reaches a bit only where the sources differ.
// [RQ17] Fast xor gives the same result in a single pulse.
// [RQ18] Fast xor pulses every bit: one where sources differ, else zero.
// [RQ19] Controller issues one input per bit, pulses 0.2 us apart.
// [RQ20] New state appears after the pulse; the pulse sees old values.
// [RQ21] Width is a parameter; every operation applies to all bits.
`ifndef RTD_REGS_SVH
`define RTD_REGS_SVH

`define RTD_OFS_REG_A    12'h000
`define RTD_OFS_REG_B    12'h004
`define RTD_OFS_REG_C    12'h008
`define RTD_OFS_CMD      12'h00c
`define RTD_OFS_STATUS   12'h010

`define RTD_CMD_OP_LSB   0
`define RTD_CMD_OP_MSB   4
`define RTD_CMD_DST_LSB  8
`define RTD_CMD_DST_MSB  9
`define RTD_CMD_SRC_LSB  12
`define RTD_CMD_SRC_MSB  13
`define RTD_CMD_SEG_BIT  16

`define RTD_RESP_OKAY    2'b00
`define RTD_RESP_SLVERR  2'b10
`define RTD_PULSE_GAP_NS 200
`define RTD_CLK_NS       100

`endif

// ### verilog/rtd_pkg.sv
/*
 * Types of the register transfer datapath: operation codes, register
 * selectors and the decoded command carried between processes.
 * Assumes rtd_regs.svh supplies the numeric layout.
 */
package rtd_pkg;

    typedef enum logic [4:0] {
        RTD_OP_NONE     = 5'h00,
        RTD_OP_CLEAR    = 5'h01,
        RTD_OP_SET      = 5'h02,
        RTD_OP_COMPL    = 5'h03,
        RTD_OP_JAM      = 5'h04,
        RTD_OP_ZEROS    = 5'h05,
        RTD_OP_ONES     = 5'h06,
        RTD_OP_SHL      = 5'h07,
        RTD_OP_SHR      = 5'h08,
        RTD_OP_PERMUTE  = 5'h09,
        RTD_OP_XOR2     = 5'h0a,
        RTD_OP_OR3      = 5'h0b,
        RTD_OP_XOR3_SET = 5'h0c,
        RTD_OP_XOR3_ONE = 5'h0d,
        RTD_OP_ZERO_CLR = 5'h0e
    } rtd_op_e;

    typedef enum logic [1:0] {
        RTD_SEL_A = 2'b00,
        RTD_SEL_B = 2'b01,
        RTD_SEL_C = 2'b10
    } rtd_sel_e;

    typedef struct packed {
        logic     seg;
        rtd_sel_e src;
        rtd_sel_e dst;
        rtd_op_e  op;
    } rtd_cmd_s;

    typedef enum logic [1:0] {
        RTD_GAP_IDLE = 2'b00,
        RTD_GAP_WAIT = 2'b01
    } rtd_gap_e;

endpackage

// ### verilog/rtd_datapath.sv
/*
 * Register transfer datapath: three word registers A, B, C driven by
 * transfer pulses written to a command register over AXI4-Lite.
 * Assumes one master, one write and one read in flight at most, and a
 * 10 MHz aclk with synchronous active-low reset.
 */
`timescale 1ns/1ns
`include "rtd_regs.svh"

module rtd_datapath #(
    parameter int WIDTH   = 36,
    parameter int SEG_W   = 9,
    parameter int SUB_W   = 18
) (
    input  wire logic        aclk,
    input  wire logic        aresetn,
    input  wire logic [11:0] s_axi_awaddr,
    input  wire logic        s_axi_awvalid,
    output logic             s_axi_awready,
    input  wire logic [31:0] s_axi_wdata,
    input  wire logic [3:0]  s_axi_wstrb,
    input  wire logic        s_axi_wvalid,
    output logic             s_axi_wready,
    output logic [1:0]       s_axi_bresp,
    output logic             s_axi_bvalid,
    input  wire logic        s_axi_bready,
    input  wire logic [11:0] s_axi_araddr,
    input  wire logic        s_axi_arvalid,
    output logic             s_axi_arready,
    output logic [31:0]      s_axi_rdata,
    output logic [1:0]       s_axi_rresp,
    output logic             s_axi_rvalid,
    input  wire logic        s_axi_rready,
    output logic [WIDTH-1:0] reg_a,
    output logic [WIDTH-1:0] reg_b,
    output logic [WIDTH-1:0] reg_c,
    output logic             busy
);

    // Register words hold the low 32 bits; wider words keep upper bits
    // reachable only through the datapath itself.
    localparam int DW = (WIDTH < 32) ? WIDTH : 32;
    localparam int GAP_CYC =
        (`RTD_PULSE_GAP_NS + `RTD_CLK_NS - 1) / `RTD_CLK_NS;
    localparam int GAP_W = 4;

    // Refused at elaboration: rings and subword pairs must tile the word
    if (WIDTH < 2 || WIDTH % SEG_W != 0 || WIDTH % (2 * SUB_W) != 0
        || SEG_W < 2 || SUB_W < 1 || GAP_CYC >= (1 << GAP_W)) begin
        $error("rtd_datapath: unsupported parameters");
    end

    logic [WIDTH-1:0] a_q, b_q, c_q;
    logic [WIDTH-1:0] a_d, b_d, c_d;
    rtd_pkg::rtd_cmd_s cmd;
    logic             pulse;
    logic [GAP_W-1:0] gap_q;
    logic             aw_hold_q, w_hold_q;
    logic [11:0]      awaddr_q;
    logic [31:0]      wdata_q;
    logic [3:0]       wstrb_q;
    logic             wr_go;
    logic [WIDTH-1:0] src, dst, res;
    logic [31:0]      rd_word;

    function automatic logic [WIDTH-1:0] rot_left(
        input logic [WIDTH-1:0] v,
        input logic             seg
    );
        logic [WIDTH-1:0] r;
        r = {v[WIDTH-2:0], v[WIDTH-1]};
        if (seg) begin
            for (int s = 0; s < WIDTH / SEG_W; s++) begin
                r[s*SEG_W +: SEG_W] =
                    {v[s*SEG_W +: SEG_W-1], v[s*SEG_W+SEG_W-1]};
            end
        end
        return r;
    endfunction

    function automatic logic [WIDTH-1:0] rot_right(
        input logic [WIDTH-1:0] v,
        input logic             seg
    );
        logic [WIDTH-1:0] r;
        r = {v[0], v[WIDTH-1:1]};
        if (seg) begin
            for (int s = 0; s < WIDTH / SEG_W; s++) begin
                r[s*SEG_W +: SEG_W] =
                    {v[s*SEG_W], v[s*SEG_W+1 +: SEG_W-1]};
            end
        end
        return r;
    endfunction

    function automatic logic [WIDTH-1:0] pick(
        input rtd_pkg::rtd_sel_e sel,
        input logic [WIDTH-1:0]  a,
        input logic [WIDTH-1:0]  b,
        input logic [WIDTH-1:0]  c
    );
        logic [WIDTH-1:0] r;
        unique case (sel)
            rtd_pkg::RTD_SEL_A: r = a;
            rtd_pkg::RTD_SEL_B: r = b;
            rtd_pkg::RTD_SEL_C: r = c;
            default:            r = a;
        endcase
        return r;
    endfunction

    function automatic logic [WIDTH-1:0] merge_word(
        input logic [WIDTH-1:0] old,
        input logic [31:0]      data,
        input logic [3:0]       strb
    );
        logic [WIDTH-1:0] r;
        r = old;
        for (int i = 0; i < DW; i++) begin
            if (strb[i/8]) begin
                r[i] = data[i];
            end
        end
        return r;
    endfunction

    // Write channels are taken in either order and held until both arrive
    assign s_axi_awready = !aw_hold_q && !s_axi_bvalid;
    assign s_axi_wready  = !w_hold_q && !s_axi_bvalid;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_hold_q <= 1'b0;
            awaddr_q  <= 12'h000;
        end else if (wr_go) begin
            aw_hold_q <= 1'b0;
        end else if (s_axi_awvalid && s_axi_awready) begin
            aw_hold_q <= 1'b1;
            awaddr_q  <= s_axi_awaddr;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            w_hold_q <= 1'b0;
            wdata_q  <= 32'h0000_0000;
            wstrb_q  <= 4'h0;
        end else if (wr_go) begin
            w_hold_q <= 1'b0;
        end else if (s_axi_wvalid && s_axi_wready) begin
            w_hold_q <= 1'b1;
            wdata_q  <= s_axi_wdata;
            wstrb_q  <= s_axi_wstrb;
        end
    end

    assign wr_go = aw_hold_q && w_hold_q;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_bvalid <= 1'b0;
            s_axi_bresp  <= `RTD_RESP_OKAY;
        end else if (wr_go) begin
            s_axi_bvalid <= 1'b1;
            unique case (awaddr_q)
                `RTD_OFS_REG_A, `RTD_OFS_REG_B, `RTD_OFS_REG_C,
                `RTD_OFS_CMD: s_axi_bresp <= `RTD_RESP_OKAY;
                default:      s_axi_bresp <= `RTD_RESP_SLVERR;
            endcase
        end else if (s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
        end
    end

    // A command write is one transfer pulse; the command is decoded live
    assign cmd   = rtd_pkg::rtd_cmd_s'({wdata_q[`RTD_CMD_SEG_BIT],
                       wdata_q[`RTD_CMD_SRC_MSB:`RTD_CMD_SRC_LSB],
                       wdata_q[`RTD_CMD_DST_MSB:`RTD_CMD_DST_LSB],
                       wdata_q[`RTD_CMD_OP_MSB:`RTD_CMD_OP_LSB]});
    assign pulse = wr_go && awaddr_q == `RTD_OFS_CMD;

    // Pulses closer than the bit recovery time are spaced by software;
    // busy only reports the window so software can poll it.
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            gap_q <= '0;
        end else if (pulse) begin
            gap_q <= GAP_W'(GAP_CYC); // [RQ19]
        end else if (gap_q != '0) begin
            gap_q <= gap_q - 1'b1;
        end
    end
    assign busy = gap_q != '0;

    // Result for the destination, computed from pre-pulse values only
    always_comb begin
        src = pick(cmd.src, a_q, b_q, c_q); // [RQ3]
        dst = pick(cmd.dst, a_q, b_q, c_q);
        res = dst;
        unique case (cmd.op)
            rtd_pkg::RTD_OP_CLEAR:    res = '0;    // [RQ1] [RQ5] [RQ12] [RQ15]
            rtd_pkg::RTD_OP_SET:      res = '1;    // [RQ1]
            rtd_pkg::RTD_OP_COMPL:    res = ~dst;  // [RQ1]
            rtd_pkg::RTD_OP_JAM:      res = src;   // [RQ2]
            rtd_pkg::RTD_OP_ONES:     res = dst | src; // [RQ4] [RQ5] [RQ6] [RQ14]
            rtd_pkg::RTD_OP_ZEROS:    res = dst & src; // [RQ4] [RQ6]
            rtd_pkg::RTD_OP_ZERO_CLR: res = dst & ~src; // [RQ6]
            rtd_pkg::RTD_OP_SHL:      res = rot_left(dst, cmd.seg);  // [RQ7] [RQ8] [RQ9]
            rtd_pkg::RTD_OP_SHR:      res = rot_right(dst, cmd.seg); // [RQ7] [RQ8] [RQ9]
            rtd_pkg::RTD_OP_PERMUTE: begin
                for (int p = 0; p < WIDTH / (2 * SUB_W); p++) begin
                    res[2*p*SUB_W +: SUB_W]         =
                        dst[(2*p+1)*SUB_W +: SUB_W]; // [RQ10]
                    res[(2*p+1)*SUB_W +: SUB_W]     =
                        dst[2*p*SUB_W +: SUB_W];     // [RQ10]
                end
            end
            rtd_pkg::RTD_OP_XOR2:     res = dst ^ src;    // [RQ11]
            rtd_pkg::RTD_OP_OR3:      res = c_q | (a_q | b_q); // [RQ12] [RQ13]
            rtd_pkg::RTD_OP_XOR3_SET: res = c_q | (a_q ^ b_q); // [RQ15] [RQ16]
            rtd_pkg::RTD_OP_XOR3_ONE: res = a_q ^ b_q;    // [RQ17] [RQ18]
            default:                  res = dst;
        endcase
    end

    // Three-register ops always land in C regardless of the dst field
    function automatic logic to_c(input rtd_pkg::rtd_op_e op);
        return op == rtd_pkg::RTD_OP_OR3 || op == rtd_pkg::RTD_OP_XOR3_SET
            || op == rtd_pkg::RTD_OP_XOR3_ONE;
    endfunction

    always_comb begin
        a_d = a_q;
        b_d = b_q;
        c_d = c_q;
        if (pulse && to_c(cmd.op)) begin
            c_d = res;
        end else if (pulse) begin
            unique case (cmd.dst)
                rtd_pkg::RTD_SEL_A: a_d = res;
                rtd_pkg::RTD_SEL_B: b_d = res;
                rtd_pkg::RTD_SEL_C: c_d = res;
                default:            c_d = c_q;
            endcase
        end else if (wr_go) begin
            unique case (awaddr_q)
                `RTD_OFS_REG_A: a_d = merge_word(a_q, wdata_q, wstrb_q);
                `RTD_OFS_REG_B: b_d = merge_word(b_q, wdata_q, wstrb_q);
                `RTD_OFS_REG_C: c_d = merge_word(c_q, wdata_q, wstrb_q);
                default:        a_d = a_q;
            endcase
        end
    end

    // Edge-triggered storage: the pulse samples old values [RQ20] [RQ21]
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            a_q <= '0;
            b_q <= '0;
            c_q <= '0;
        end else begin
            a_q <= a_d;
            b_q <= b_d;
            c_q <= c_d;
        end
    end

    assign reg_a = a_q;
    assign reg_b = b_q;
    assign reg_c = c_q;

    // Read side
    always_comb begin
        rd_word = 32'h0000_0000;
        unique case (s_axi_araddr)
            `RTD_OFS_REG_A:  rd_word[DW-1:0] = a_q[DW-1:0];
            `RTD_OFS_REG_B:  rd_word[DW-1:0] = b_q[DW-1:0];
            `RTD_OFS_REG_C:  rd_word[DW-1:0] = c_q[DW-1:0];
            `RTD_OFS_STATUS: rd_word[0]      = busy;
            default:         rd_word = 32'h0000_0000;
        endcase
    end

    assign s_axi_arready = !s_axi_rvalid;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_rvalid <= 1'b0;
            s_axi_rdata  <= 32'h0000_0000;
            s_axi_rresp  <= `RTD_RESP_OKAY;
        end else if (s_axi_arvalid && s_axi_arready) begin
            s_axi_rvalid <= 1'b1;
            s_axi_rdata  <= rd_word;
            unique case (s_axi_araddr)
                `RTD_OFS_REG_A, `RTD_OFS_REG_B, `RTD_OFS_REG_C,
                `RTD_OFS_STATUS: s_axi_rresp <= `RTD_RESP_OKAY;
                default:         s_axi_rresp <= `RTD_RESP_SLVERR;
            endcase
        end else if (s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
        end
    end

    AST_SOURCE_KEPT: assert property (@(posedge aclk) // [RQ3]
        disable iff (!aresetn) pulse && cmd.op == rtd_pkg::RTD_OP_JAM
        && cmd.src == rtd_pkg::RTD_SEL_A && cmd.dst != rtd_pkg::RTD_SEL_A
        |=> $stable(a_q))
        else $error("Jam source changed");

    AST_JAM_COPY: assert property (@(posedge aclk) // [RQ2]
        disable iff (!aresetn) pulse && cmd.op == rtd_pkg::RTD_OP_JAM
        && cmd.dst == rtd_pkg::RTD_SEL_C |=> c_q == $past(src))
        else $error("Jam did not copy source");

    AST_CLEAR_ZERO: assert property (@(posedge aclk) // [RQ1]
        disable iff (!aresetn) pulse && cmd.op == rtd_pkg::RTD_OP_CLEAR
        && cmd.dst == rtd_pkg::RTD_SEL_C |=> c_q == '0)
        else $error("Clear left ones");

    AST_ONES_OR: assert property (@(posedge aclk) // [RQ14]
        disable iff (!aresetn) pulse && cmd.op == rtd_pkg::RTD_OP_ONES
        && cmd.dst == rtd_pkg::RTD_SEL_C
        |=> c_q == ($past(c_q) | $past(src)))
        else $error("Ones transfer wrong");

    AST_ZEROS_AND: assert property (@(posedge aclk) // [RQ6]
        disable iff (!aresetn) pulse && cmd.op == rtd_pkg::RTD_OP_ZEROS
        && cmd.dst == rtd_pkg::RTD_SEL_C
        |=> c_q == ($past(c_q) & $past(src)))
        else $error("Zeros transfer wrong");

    AST_XOR2: assert property (@(posedge aclk) // [RQ11]
        disable iff (!aresetn) pulse && cmd.op == rtd_pkg::RTD_OP_XOR2
        && cmd.dst == rtd_pkg::RTD_SEL_A
        |=> a_q == ($past(a_q) ^ $past(src)))
        else $error("Complement xor wrong");

    AST_OR3_INTO_C: assert property (@(posedge aclk) // [RQ12] [RQ13]
        disable iff (!aresetn) pulse && cmd.op == rtd_pkg::RTD_OP_OR3
        |=> c_q == ($past(c_q) | $past(a_q) | $past(b_q)))
        else $error("Or into C wrong");

    AST_XOR3_ONE: assert property (@(posedge aclk) // [RQ17] [RQ18]
        disable iff (!aresetn) pulse && cmd.op == rtd_pkg::RTD_OP_XOR3_ONE
        |=> c_q == ($past(a_q) ^ $past(b_q)))
        else $error("Single pulse xor wrong");

    AST_XOR3_SET: assert property (@(posedge aclk) // [RQ16]
        disable iff (!aresetn) pulse && cmd.op == rtd_pkg::RTD_OP_XOR3_SET
        |=> (c_q & ~$past(c_q))
        == (($past(a_q) ^ $past(b_q)) & ~$past(c_q)))
        else $error("Xor set pulse wrong");

    AST_SHL_RING: assert property (@(posedge aclk) // [RQ8]
        disable iff (!aresetn) pulse && cmd.op == rtd_pkg::RTD_OP_SHL
        && !cmd.seg && cmd.dst == rtd_pkg::RTD_SEL_A
        |=> a_q[0] == $past(a_q[WIDTH-1]))
        else $error("Ring end bit lost");

    AST_SHR_MOVE: assert property (@(posedge aclk) // [RQ7]
        disable iff (!aresetn) pulse && cmd.op == rtd_pkg::RTD_OP_SHR
        && !cmd.seg && cmd.dst == rtd_pkg::RTD_SEL_B
        |=> b_q[WIDTH-2:0] == $past(b_q[WIDTH-1:1]))
        else $error("Shift right misplaced bits");

    AST_SEG_RING: assert property (@(posedge aclk) // [RQ9]
        disable iff (!aresetn) pulse && cmd.op == rtd_pkg::RTD_OP_SHR
        && cmd.seg && cmd.dst == rtd_pkg::RTD_SEL_A
        |=> a_q[SEG_W-1] == $past(a_q[0]))
        else $error("Segment ring end bit lost");

    AST_PERMUTE_SWAP: assert property (@(posedge aclk) // [RQ10]
        disable iff (!aresetn) pulse && cmd.op == rtd_pkg::RTD_OP_PERMUTE
        && cmd.dst == rtd_pkg::RTD_SEL_B
        |=> b_q[SUB_W-1:0] == $past(b_q[2*SUB_W-1:SUB_W])
        && b_q[2*SUB_W-1:SUB_W] == $past(b_q[SUB_W-1:0]))
        else $error("Permute did not swap subwords");

    AST_COMPL_ALL: assert property (@(posedge aclk) // [RQ1]
        disable iff (!aresetn) pulse && cmd.op == rtd_pkg::RTD_OP_COMPL
        && cmd.dst == rtd_pkg::RTD_SEL_B |=> b_q == ~$past(b_q))
        else $error("Complement missed bits");

    AST_BUSY_GAP: assert property (@(posedge aclk) // [RQ19]
        disable iff (!aresetn) pulse |=> busy [*2] ##1 (!busy || pulse))
        else $error("Busy window wrong");

endmodule

// ### verification/rtd_ctrl_model.sv
/*
 * Control and timing side model: issues commands to the datapath as
 * AXI4-Lite writes and reads registers back.
 * Assumes the datapath answers each channel in its own handshake.
 */
`timescale 1ns/1ns
`include "rtd_regs.svh"
module rtd_ctrl_model (
    input  wire logic        aclk,
    input  wire logic        busy,
    output logic [11:0]      awaddr,
    output logic             awvalid,
    input  wire logic        awready,
    output logic [31:0]      wdata,
    output logic [3:0]       wstrb,
    output logic             wvalid,
    input  wire logic        wready,
    input  wire logic [1:0]  bresp,
    input  wire logic        bvalid,
    output logic             bready,
    output logic [11:0]      araddr,
    output logic             arvalid,
    input  wire logic        arready,
    input  wire logic [31:0] rdata,
    input  wire logic [1:0]  rresp,
    input  wire logic        rvalid,
    output logic             rready
);
    initial begin
        {awvalid, wvalid, bready, arvalid, rready} = 5'h00;
        {awaddr, araddr, wdata, wstrb} = '0;
    end

    // Released address and data lines show the inverse (wstrb keeps its value), so stale data cannot pass
    task automatic write(input logic [11:0] a, input logic [31:0] d,
                         input logic [3:0] s, output logic [1:0] r);
        logic aw_d;
        logic w_d;
        aw_d = 1'b0;
        w_d = 1'b0;
        @(posedge aclk);
        awaddr  <= a;
        wdata   <= d;
        wstrb   <= s;
        awvalid <= 1'b1;
        wvalid  <= 1'b1;
        bready  <= 1'b1;
        do begin
            @(posedge aclk);
            if (!aw_d && awready) begin
                aw_d = 1'b1;
                awvalid <= 1'b0;
                awaddr  <= ~a;
            end
            if (!w_d && wready) begin
                w_d = 1'b1;
                wvalid <= 1'b0;
                wdata  <= ~d;
            end
        end while (!bvalid);
        r = bresp;
        bready <= 1'b0;
    endtask

    task automatic read(input logic [11:0] a, output logic [31:0] d,
                        output logic [1:0] r);
        @(posedge aclk);
        araddr  <= a;
        arvalid <= 1'b1;
        rready  <= 1'b1;
        do begin
            @(posedge aclk);
            if (arvalid && arready) begin
                arvalid <= 1'b0;
                araddr  <= ~a;
            end
        end while (!rvalid);
        d = rdata;
        r = rresp;
        rready <= 1'b0;
    endtask

    // One command at a time, next only once the gap has passed
    task automatic pulse(input logic [31:0] cmd);
        logic [1:0] r;
        write(`RTD_OFS_CMD, cmd, 4'hf, r);
        while (busy) @(posedge aclk);
    endtask

    // Clear pulse strictly before the setting pulse
    task automatic two_pulse(input logic [31:0] clr, input logic [31:0] cmd);
        pulse(clr);
        pulse(cmd);
    endtask
endmodule

// ### verification/rtd_datapath_tb.sv
/*
 * Self-checking bench of the register transfer datapath: commands go
 * through the control model, results are compared with a word model.
 * Assumes 10 MHz aclk and writes that keep bits above 32 unchanged.
 */
`timescale 1ns/1ns
`include "rtd_regs.svh"
`define CHK(n, x, g) begin \
    total_checks++; \
    if ((g) !== (x)) begin \
        bad_count++; \
        $display("ERROR %s exp %h got %h", n, x, g); \
    end \
end
module rtd_datapath_tb;
    localparam int W = 36;
    logic          aclk;
    logic          aresetn;
    logic [11:0]   awaddr, araddr;
    logic [31:0]   wdata, rdata;
    logic [3:0]    wstrb;
    logic [1:0]    bresp, rresp;
    logic          awvalid, awready, wvalid, wready, bvalid, bready;
    logic          arvalid, arready, rvalid, rready, busy;
    logic [W-1:0]  reg_a, reg_b, reg_c;
    logic [W-1:0]  e [3];
    int            bad_count = 0;
    int            total_checks = 0;

    rtd_datapath #(.WIDTH(W), .SEG_W(9), .SUB_W(18)) i_rtd_datapath (
        .aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr),
        .s_axi_awvalid(awvalid), .s_axi_awready(awready),
        .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid),
        .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
        .s_axi_bready(bready), .s_axi_araddr(araddr),
        .s_axi_arvalid(arvalid), .s_axi_arready(arready),
        .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
        .s_axi_rready(rready), .reg_a(reg_a), .reg_b(reg_b),
        .reg_c(reg_c), .busy(busy));

    rtd_ctrl_model i_rtd_ctrl_model (
        .aclk(aclk), .busy(busy), .awaddr(awaddr), .awvalid(awvalid),
        .awready(awready), .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid),
        .wready(wready), .bresp(bresp), .bvalid(bvalid), .bready(bready),
        .araddr(araddr), .arvalid(arvalid), .arready(arready),
        .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready));

    initial begin
        aclk = 1'b0;
        forever #50 aclk = ~aclk;
    end

    task automatic print_verdict();
        if (bad_count == 0 && total_checks > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask

    // Bounded by far more than the whole sequence needs
    initial begin
        #2000000;
        bad_count++;
        print_verdict();
    end

    function automatic logic [W-1:0] ring(logic [W-1:0] v, logic l,
                                          logic g);
        logic [W-1:0] r;
        int           n;
        int           b;
        for (int i = 0; i < W; i++) begin
            n = g ? 9 : W;
            b = (i / n) * n;
            r[i] = v[b + (i - b + (l ? n - 1 : 1)) % n];
        end
        return r;
    endfunction

    task automatic chk_regs();
        `CHK("reg_a", e[0], reg_a)
        `CHK("reg_b", e[1], reg_b)
        `CHK("reg_c", e[2], reg_c)
    endtask

    task automatic wr(input logic [11:0] a, input logic [31:0] d,
                      input logic [3:0] s, input logic [1:0] er);
        logic [1:0] r;
        i_rtd_ctrl_model.write(a, d, s, r);
        `CHK("bresp", er, r)
        if (er === `RTD_RESP_OKAY && a != `RTD_OFS_CMD)
            for (int k = 0; k < 4; k++)
                if (s[k]) e[a[3:2]][8*k +: 8] = d[8*k +: 8];
        chk_regs();
    endtask

    task automatic rd(input logic [11:0] a, input logic [31:0] ed,
                      input logic [1:0] er);
        logic [31:0] d;
        logic [1:0]  r;
        i_rtd_ctrl_model.read(a, d, r);
        `CHK("rresp", er, r)
        `CHK("rdata", ed, d)
    endtask

    // Op codes follow the command layout of the package enum
    task automatic run(input logic [4:0] op, input logic [1:0] d,
                       input logic [1:0] s, input logic g, input logic pre);
        logic [W-1:0] x;
        logic [31:0]  cmd;
        cmd = {15'h0, g, 2'h0, s, 2'h0, d, 3'h0, op};
        x = pre ? '0 : e[d];
        case (op)
            5'h01: x = '0;
            5'h02: x = '1;
            5'h03: x = ~x;
            5'h04: x = e[s];
            5'h05: x = x & e[s];
            5'h06: x = x | e[s];
            5'h07: x = ring(x, 1'b1, g);
            5'h08: x = ring(x, 1'b0, g);
            5'h09: x = {x[17:0], x[35:18]};
            5'h0a: x = x ^ e[s];
            5'h0b: x = x | e[0] | e[1];
            5'h0c: x = x | (e[0] ^ e[1]);
            5'h0d: x = e[0] ^ e[1];
            5'h0e: x = x & ~e[s];
            default: x = x;
        endcase
        if (pre) i_rtd_ctrl_model.two_pulse({22'h0, d, 8'h01}, cmd);
        else i_rtd_ctrl_model.pulse(cmd);
        e[d] = x;
        repeat (2) @(posedge aclk);
        chk_regs();
    endtask

    initial begin
        aresetn = 1'b0;
        e[0] = '0;
        e[1] = '0;
        e[2] = '0;
        repeat (6) @(posedge aclk);
        aresetn <= 1'b1;
        @(posedge aclk);
        chk_regs();
        rd(`RTD_OFS_REG_A, 32'h0, `RTD_RESP_OKAY);
        run(5'h02, 0, 0, 0, 0);
        run(5'h02, 1, 0, 0, 0);
        wr(`RTD_OFS_REG_A, 32'h0f0f3c5a, 4'hf, `RTD_RESP_OKAY);
        wr(`RTD_OFS_REG_B, 32'h33cc55aa, 4'hf, `RTD_RESP_OKAY);
        run(5'h03, 1, 0, 0, 0);
        run(5'h04, 2, 0, 0, 0);
        run(5'h01, 2, 0, 0, 0);
        run(5'h06, 2, 1, 0, 0);
        run(5'h05, 2, 0, 0, 0);
        run(5'h0e, 0, 1, 0, 0);
        run(5'h06, 2, 0, 0, 1);
        run(5'h07, 0, 0, 0, 0);
        run(5'h08, 1, 0, 0, 0);
        run(5'h07, 0, 0, 1, 0);
        run(5'h08, 0, 0, 1, 0);
        run(5'h09, 1, 0, 0, 0);
        run(5'h0a, 0, 1, 0, 0);
        run(5'h0b, 2, 0, 0, 1);
        run(5'h0a, 2, 0, 0, 0);
        run(5'h0b, 2, 0, 0, 0);
        run(5'h0c, 2, 0, 0, 1);
        run(5'h02, 2, 0, 0, 0);
        run(5'h0d, 2, 0, 0, 0);
        wr(`RTD_OFS_REG_A, 32'hdeadbeef, 4'h5, `RTD_RESP_OKAY);
        rd(`RTD_OFS_REG_A, e[0][31:0], `RTD_RESP_OKAY);
        rd(`RTD_OFS_REG_B, e[1][31:0], `RTD_RESP_OKAY);
        rd(`RTD_OFS_REG_C, e[2][31:0], `RTD_RESP_OKAY);
        rd(`RTD_OFS_STATUS, 32'h0, `RTD_RESP_OKAY);
        // Empty command: no register moves, but the gap window still opens
        wr(`RTD_OFS_CMD, 32'h0, 4'hf, `RTD_RESP_OKAY);
        @(negedge aclk);
        `CHK("busy", 1'b1, busy)
        @(negedge aclk);
        `CHK("busy", 1'b0, busy)
        wr(12'h020, 32'h12345678, 4'hf, `RTD_RESP_SLVERR);
        wr(`RTD_OFS_STATUS, 32'h1, 4'hf, `RTD_RESP_SLVERR);
        rd(12'h020, 32'h0, `RTD_RESP_SLVERR);
        print_verdict();
    end
endmodule
